// [inc/adc_ctrl_map.svh]
// constant map of the converter control block: offsets, fields, counts
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
//
// Summary of operation
// RULE1: a single-ended result is the unsigned code vin*1024/vref, 0x000 at ground and 0x3ff at full scale.
// RULE2: a differential result is the two's-complement code vdiff*512/vref from 0x200 to 0x1ff, saturating at 0x1ff.
// RULE3: the finished result lands in the low and high result registers when the done flag is raised.
// RULE4: reference code 00 picks the external pin, 01 the analog supply, 10 nothing, 11 the internal 1.1V source.
// RULE5: reference and channel changes written during a conversion wait until that conversion has completed.
// RULE6: the left-justify bit repacks the presented result at once, even while a conversion runs.
// RULE7: channel codes 00000 to 00111 pick single-ended input n; 01000 to 01111 select nothing.
// RULE8: codes 10000-10111 pick inputs 0-7 against input 1; codes 11000-11101 pick inputs 0-5 against input 2.
// RULE9: channel code 11110 routes the bandgap voltage to the converter and 11111 routes ground.
// RULE10: the enable bit powers the converter; clearing it aborts a running conversion.
// RULE11: after the low result is read both result registers hold until the high result is read.
// RULE12: the first conversion after enabling takes 25 converter clocks, later ones take 13.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define OFS_INPUT_SELECT 8'h00
`define OFS_CONTROL_A 8'h04
`define OFS_RESULT_LOW 8'h08
`define OFS_RESULT_HIGH 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_FLAG 4
`define BIT_LEFT 5
`define IRQ_DONE 0
`define IRQ_ABORT 1

`define REF_RESERVED 2'h2
`define FIRST_CONV_CYCLES 5'h19
`define NORM_CONV_CYCLES 5'h0d
`define FULL_SCALE_SE 10'h3ff
`define FULL_SCALE_DIFF 10'h1ff
`define RESET_BYTE 8'h00

`endif

// [inc/adc_ctrl_pkg.sv]
// types shared by the converter control block
// assumes nothing beyond the constant map
package adc_ctrl_pkg;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONVERT = 1'b1
    } conv_state_t;

    typedef struct packed {
        logic valid;
        logic diff;
        logic bandgap;
        logic ground;
        logic [2:0] pos;
        logic [2:0] neg;
    } route_t;
endpackage

// [rtl/adc_mux_result_control.sv]
// digital control around a 10-bit successive-approximation converter
// assumes an avalon-mm master on clk and an analog core that returns
// an 11-bit code asynchronously (0..1024 of full scale, offset by 512 when differential)
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"

module adc_mux_result_control (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    input wire logic [10:0] core_code,
    output logic core_power_on,
    output logic core_sample,
    output logic [1:0] core_ref_select,
    output logic core_ref_valid,
    output logic core_channel_valid,
    output logic core_diff_mode,
    output logic core_bandgap_sel,
    output logic core_ground_sel,
    output logic [2:0] core_pos_input,
    output logic [2:0] core_neg_input
);

    // ****************************************
    // functions
    // ****************************************
    function automatic adc_ctrl_pkg::route_t decode_channel(input logic [4:0] code);
        adc_ctrl_pkg::route_t r;
        begin
            r = '0;
            if (code[4:3] == 2'b00) begin // [RULE7]
                r.valid = 1'b1;
                r.pos = code[2:0];
            end else if (code[4:3] == 2'b10) begin // [RULE8]
                r.valid = 1'b1;
                r.diff = 1'b1;
                r.pos = code[2:0];
                r.neg = 3'h1;
            end else if (code[4:3] == 2'b11 && code[2:1] != 2'b11) begin // [RULE8]
                r.valid = 1'b1;
                r.diff = 1'b1;
                r.pos = code[2:0];
                r.neg = 3'h2;
            end else if (code == 5'h1e) begin // [RULE9]
                r.valid = 1'b1;
                r.bandgap = 1'b1;
            end else if (code == 5'h1f) begin // [RULE9]
                r.valid = 1'b1;
                r.ground = 1'b1;
            end
            decode_channel = r;
        end
    endfunction

    function automatic logic [9:0] to_result(input logic [10:0] code, input logic diff);
        begin
            if (!diff) begin
                to_result = code[10] ? `FULL_SCALE_SE : code[9:0]; // [RULE1]
            end else if (code[10]) begin
                to_result = `FULL_SCALE_DIFF; // [RULE2]
            end else begin
                to_result = {~code[9], code[8:0]}; // [RULE2]
            end
        end
    endfunction

    function automatic logic [6:0] div_max(input logic [2:0] ps);
        begin
            div_max = (ps == 3'h0) ? 7'h01 : 7'((8'h01 << ps) - 8'h01);
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [7:0] input_select_control;
    logic [2:0] prescale;
    logic converter_enable;
    logic conversion_start;
    logic first_pending;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [9:0] result;
    logic locked;
    logic ack;
    logic [6:0] presc_cnt;
    logic [4:0] conv_left;
    logic active_diff;
    logic [10:0] code_meta;
    logic [10:0] code_sync;
    adc_ctrl_pkg::conv_state_t state;

    // ****************************************
    // decode
    // ****************************************
    wire req = (read || write) && !ack;
    wire wr = write && ack && byteenable[0];
    wire rd = read && ack;
    wire wr_sel = wr && address == `OFS_INPUT_SELECT;
    wire wr_ctl = wr && address == `OFS_CONTROL_A;
    wire wr_sts = wr && address == `OFS_IRQ_STATUS;
    wire wr_msk = wr && address == `OFS_IRQ_MASK;
    wire rd_low = rd && address == `OFS_RESULT_LOW;
    wire rd_high = rd && address == `OFS_RESULT_HIGH;
    wire [7:0] wbyte = writedata[7:0];
    wire left_justify = input_select_control[`BIT_LEFT];
    wire [1:0] ref_select = input_select_control[7:6];
    wire [4:0] channel_select = input_select_control[4:0];
    wire adc_tick = converter_enable && presc_cnt == div_max(prescale);
    wire busy = state == adc_ctrl_pkg::ST_CONVERT;
    wire conv_done_flag = irq_status[`IRQ_DONE];
    wire abort_pulse = busy && wr_ctl && !wbyte[`BIT_ENABLE]; // [RULE10]
    // an abort on the last tick wins: no result and no done flag
    wire done_pulse = busy && converter_enable && adc_tick && conv_left == 5'h01 && !abort_pulse;
    wire start_req = wr_ctl && wbyte[`BIT_ENABLE] && wbyte[`BIT_START];
    wire [1:0] irq_set = {abort_pulse, done_pulse};
    wire [1:0] irq_clr = (wr_sts ? wbyte[1:0] : 2'h0)
                       | (wr_ctl && wbyte[`BIT_FLAG] ? 2'h1 : 2'h0);
    wire [1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;
    wire [15:0] packed_result = left_justify ? {result, 6'h00} : {6'h00, result}; // [RULE6]
    wire [7:0] ctl_read = {converter_enable, busy, 1'b0, conv_done_flag, 1'b0, prescale};
    wire [7:0] rd_byte =
        address == `OFS_INPUT_SELECT ? input_select_control :
        address == `OFS_CONTROL_A ? ctl_read :
        address == `OFS_RESULT_LOW ? packed_result[7:0] :
        address == `OFS_RESULT_HIGH ? packed_result[15:8] :
        address == `OFS_IRQ_STATUS ? {6'h00, irq_status} :
        address == `OFS_IRQ_MASK ? {6'h00, irq_mask} : 8'h00;
    wire adc_prescale_wrap = adc_tick || !converter_enable;
    wire adc_ctrl_pkg::route_t route = decode_channel(channel_select);
    wire adc_route_ok = route.valid;

    // ****************************************
    // bus slave: one wait state per access
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack <= 1'b0;
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else begin
            ack <= req;
            waitrequest <= !req;
            if (req && read) begin
                readdata <= {24'h0, rd_byte};
            end
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            input_select_control <= `RESET_BYTE;
            prescale <= 3'h0;
            converter_enable <= 1'b0;
            irq_mask <= 2'h0;
            irq_status <= 2'h0;
            irq <= 1'b0;
        end else begin
            if (wr_sel) begin
                input_select_control <= wbyte;
            end
            if (wr_ctl) begin
                prescale <= wbyte[2:0];
                converter_enable <= wbyte[`BIT_ENABLE]; // [RULE10]
            end
            if (wr_msk) begin
                irq_mask <= wbyte[1:0];
            end
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // ****************************************
    // converter clock and conversion sequence
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            presc_cnt <= 7'h00;
        end else begin
            presc_cnt <= adc_prescale_wrap ? 7'h00 : 7'(presc_cnt + 7'h01);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= adc_ctrl_pkg::ST_IDLE;
            conv_left <= 5'h00;
            first_pending <= 1'b0;
            conversion_start <= 1'b0;
        end else begin
            // a start taken with the enable write uses the long count itself
            if (start_req && !busy) begin
                first_pending <= 1'b0;
            end else if (wr_ctl && wbyte[`BIT_ENABLE] && !converter_enable) begin
                first_pending <= 1'b1; // [RULE12]
            end
            case (state)
                adc_ctrl_pkg::ST_IDLE: begin
                    if (start_req) begin
                        state <= adc_ctrl_pkg::ST_CONVERT;
                        conversion_start <= 1'b1;
                        conv_left <= (first_pending || !converter_enable) ?
                            `FIRST_CONV_CYCLES : `NORM_CONV_CYCLES; // [RULE12]
                    end
                end
                adc_ctrl_pkg::ST_CONVERT: begin
                    if (!converter_enable || abort_pulse) begin
                        state <= adc_ctrl_pkg::ST_IDLE; // [RULE10]
                        conversion_start <= 1'b0;
                    end else if (adc_tick) begin
                        conv_left <= 5'(conv_left - 5'h01);
                        if (conv_left == 5'h01) begin
                            state <= adc_ctrl_pkg::ST_IDLE;
                            conversion_start <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= adc_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // analog side: selection held while converting
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            code_meta <= 11'h000;
            code_sync <= 11'h000;
        end else begin
            code_meta <= core_code;
            code_sync <= code_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            core_ref_select <= 2'h0;
            core_ref_valid <= 1'b1;
            core_channel_valid <= 1'b1;
            core_diff_mode <= 1'b0;
            core_bandgap_sel <= 1'b0;
            core_ground_sel <= 1'b0;
            core_pos_input <= 3'h0;
            core_neg_input <= 3'h0;
            active_diff <= 1'b0;
            core_power_on <= 1'b0;
            core_sample <= 1'b0;
        end else begin
            core_power_on <= converter_enable;
            core_sample <= busy && converter_enable;
            // start taken in idle locks what stood at that edge
            if (!busy) begin // [RULE5]
                core_ref_select <= ref_select;
                core_ref_valid <= ref_select != `REF_RESERVED; // [RULE4]
                core_channel_valid <= adc_route_ok;
                core_diff_mode <= route.diff;
                core_bandgap_sel <= route.bandgap;
                core_ground_sel <= route.ground;
                core_pos_input <= route.pos;
                core_neg_input <= route.neg;
                active_diff <= route.diff;
            end
        end
    end

    // ****************************************
    // result and read lock
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            result <= 10'h000;
            locked <= 1'b0;
        end else begin
            // a result finishing while locked is dropped, the flag still rises
            if (done_pulse && !locked) begin
                result <= to_result(code_sync, active_diff); // [RULE3]
            end
            if (rd_low) begin
                locked <= 1'b1; // [RULE11]
            end else if (rd_high) begin
                locked <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ref_hold_a: assert property (busy && $past(busy) |-> $stable(core_ref_select)) // [RULE5]
        else $error("reference changed during conversion");
    chan_hold_a: assert property (busy && $past(busy) |-> $stable(core_pos_input) && $stable(core_neg_input)) // [RULE5]
        else $error("channel changed during conversion");
    conv_len_a: assert property ($rose(busy) |-> conv_left == (($past(first_pending) || !$past(converter_enable)) ?
        `FIRST_CONV_CYCLES : `NORM_CONV_CYCLES)) // [RULE12]
        else $error("wrong conversion length loaded");
    abort_stop_a: assert property (abort_pulse |=> !busy && !$rose(conv_done_flag) && $stable(result)) // [RULE10]
        else $error("disable did not abort");
    done_flag_a: assert property (done_pulse |=> conv_done_flag && !busy) // [RULE3]
        else $error("done flag not raised");
    lock_hold_a: assert property (locked && !done_pulse |=> $stable(result)) // [RULE11]
        else $error("result moved while locked");
    lock_drop_a: assert property (locked && done_pulse |=> $stable(result) && conv_done_flag) // [RULE11]
        else $error("locked result overwritten");
    se_sat_a: assert property (done_pulse && !locked && !active_diff && code_sync[10] |=> result == 10'h3ff) // [RULE1]
        else $error("single-ended saturation wrong");
    diff_sat_a: assert property (done_pulse && !locked && active_diff && code_sync[10] |=> result == 10'h1ff) // [RULE2]
        else $error("differential saturation wrong");
    justify_a: assert property (ack && read && address == 8'h08 && $past(left_justify)
        |-> readdata[7:0] == {$past(result[1:0]), 6'h00}) // [RULE6]
        else $error("left justified low byte wrong");

endmodule

// [dv/analog_core_model.sv]
// analog core stand-in: turns the routing outputs into an 11-bit code
// assumes per-input levels already scaled to 0..1024 of full scale
`timescale 1ns/1ps

module analog_core_model #(
    parameter logic [10:0] bandgap_code = 11'h0fa
) (
    input wire logic clk,
    input wire logic power_on,
    input wire logic ref_valid,
    input wire logic channel_valid,
    input wire logic diff_mode,
    input wire logic bandgap_sel,
    input wire logic ground_sel,
    input wire logic [2:0] pos_input,
    input wire logic [2:0] neg_input,
    input wire logic [7:0][10:0] level,
    output logic [10:0] core_code
);
    // ****
    // code from routing
    // ****
    logic [10:0] noise = 11'h2aa;
    int v;

    // no reference or no input means no settled code, so the pins wander
    always @(posedge clk) begin
        noise <= ~noise;
    end

    always_comb begin
        v = int'(level[pos_input]);
        if (ground_sel) begin
            v = 0;
        end else if (bandgap_sel) begin
            v = int'(bandgap_code);
        end else if (diff_mode) begin
            v = v - int'(level[neg_input]) + 512;
        end
        v = (v < 0) ? 0 : (v > 1024) ? 1024 : v;
        core_code = (power_on && ref_valid && channel_valid) ? v[10:0] : noise;
    end
endmodule

// [dv/tb.sv]
// self-checking bench for the converter control block
// assumes the analog core stand-in and one-wait-state avalon timing
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"

module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata, q;
    logic waitrequest, irq, core_power_on, core_sample, core_ref_valid, core_channel_valid;
    logic core_diff_mode, core_bandgap_sel, core_ground_sel;
    logic [1:0] core_ref_select;
    logic [2:0] core_pos_input, core_neg_input;
    logic [10:0] core_code;
    logic [7:0][10:0] level = {11'd1024, 11'd0, 11'd341, 11'd0, 11'd300, 11'd500, 11'd0, 11'd1000};
    logic [7:0] sel_tab [9] = '{8'h03, 8'h47, 8'hde, 8'h1f, 8'h5b, 8'hd0, 8'h11, 8'h45, 8'h1d};
    logic [9:0] res_tab [9] = '{10'h12c, 10'h3ff, 10'h0fa, 10'h000, 10'h338, 10'h1ff, 10'h000, 10'h155, 10'h361};
    int failures = 0;
    int checks_done = 0;
    int n;

    always #20 clk = ~clk;

    adc_mux_result_control dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .core_code(core_code), .core_power_on(core_power_on), .core_sample(core_sample),
        .core_ref_select(core_ref_select), .core_ref_valid(core_ref_valid),
        .core_channel_valid(core_channel_valid), .core_diff_mode(core_diff_mode),
        .core_bandgap_sel(core_bandgap_sel), .core_ground_sel(core_ground_sel),
        .core_pos_input(core_pos_input), .core_neg_input(core_neg_input));

    analog_core_model #(.bandgap_code(11'h0fa)) core (.clk(clk), .power_on(core_power_on),
        .ref_valid(core_ref_valid), .channel_valid(core_channel_valid), .diff_mode(core_diff_mode),
        .bandgap_sel(core_bandgap_sel), .ground_sel(core_ground_sel), .pos_input(core_pos_input),
        .neg_input(core_neg_input), .level(level), .core_code(core_code));

    // ****
    // bus and compare tasks
    // ****
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int t;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (waitrequest !== 1'b0 && t < 50);
        q = readdata;
        if (t >= 50) begin
            failures++;
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'hf);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0, 4'hf);
        check(what, exp, q);
    endtask

    // low first, then high, as the result lock expects
    task automatic res(input logic [9:0] r, input logic left);
        rdc(`OFS_RESULT_LOW, left ? {24'h0, r[1:0], 6'h0} : {24'h0, r[7:0]}, "result_low");
        rdc(`OFS_RESULT_HIGH, left ? {24'h0, r[9:2]} : {30'h0, r[9:8]}, "result_high");
    endtask

    // enable, start, clear done flag, prescale 3: one tick every 8 clocks
    task automatic start(input logic [7:0] sel);
        wr(`OFS_INPUT_SELECT, sel);
        wr(`OFS_CONTROL_A, 8'hd3);
        for (int k = 0; k < 4 && core_sample !== 1'b1; k++) @(posedge clk);
    endtask

    task automatic finish();
        n = 0;
        while (core_sample === 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic convert(input logic [7:0] sel, input logic [9:0] r);
        start(sel);
        check("ref_select", {30'h0, sel[7:6]}, {30'h0, core_ref_select});
        check("ref_valid", {31'h0, sel[7:6] != 2'h2}, {31'h0, core_ref_valid});
        check("channel_valid", {31'h0, sel[4:3] != 2'h1}, {31'h0, core_channel_valid});
        finish();
        if (sel[7:6] != 2'h2 && sel[4:3] != 2'h1) begin
            res(r, sel[5]);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****
    // tests
    // ****
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0, "reset_value");
        bus(1'b1, `OFS_INPUT_SELECT, 32'h5, 4'he);
        rdc(`OFS_INPUT_SELECT, 32'h0, "byteenable_off");
        $display("test reset finished");
        convert(8'h03, 10'h12c);
        check("first_length", 32'h1, {31'h0, n > 24 * 8 && n <= 25 * 8 + 2});
        convert(8'h03, 10'h12c);
        check("later_length", 32'h1, {31'h0, n > 12 * 8 && n <= 13 * 8 + 2});
        $display("test timing finished");
        for (int i = 0; i < 9; i++) convert(sel_tab[i], res_tab[i]);
        $display("test routing finished");
        start(8'h03);
        wr(`OFS_INPUT_SELECT, 8'h67);
        check("held_channel", 32'h3, {29'h0, core_pos_input});
        check("held_ref", 32'h0, {30'h0, core_ref_select});
        res(10'h361, 1'b1);
        finish();
        res(10'h12c, 1'b1);
        convert(8'h67, 10'h3ff);
        $display("test deferral finished");
        rdc(`OFS_RESULT_LOW, 32'hc0, "lock_low");
        start(8'h23);
        finish();
        rdc(`OFS_RESULT_HIGH, 32'hff, "lock_high");
        convert(8'h88, 10'h0);
        convert(8'h23, 10'h12c);
        $display("test lock finished");
        wr(`OFS_IRQ_STATUS, 8'h03);
        start(8'h03);
        repeat (8) @(posedge clk);
        wr(`OFS_CONTROL_A, 8'h03);
        // core outputs follow the abort one registered cycle later
        repeat (2) @(posedge clk);
        check("abort_sample", 32'h0, {31'h0, core_sample});
        check("abort_power", 32'h0, {31'h0, core_power_on});
        rdc(`OFS_CONTROL_A, 32'h03, "abort_ctrl");
        rdc(`OFS_IRQ_STATUS, 32'h02, "abort_status");
        res(10'h12c, 1'b0);
        $display("test abort finished");
        wr(`OFS_IRQ_STATUS, 8'h03);
        wr(`OFS_IRQ_MASK, 8'h01);
        convert(8'h03, 10'h12c);
        check("irq_raised", 32'h1, {31'h0, irq});
        rdc(`OFS_CONTROL_A, 32'h93, "done_flag");
        wr(`OFS_IRQ_STATUS, 8'h01);
        @(posedge clk);
        check("irq_cleared", 32'h0, {31'h0, irq});
        wr(`OFS_IRQ_MASK, 8'h00);
        convert(8'h03, 10'h12c);
        check("irq_masked", 32'h0, {31'h0, irq});
        rdc(`OFS_IRQ_STATUS, 32'h01, "status_masked");
        $display("test interrupt finished");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
